// ### verif/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] OK = wakeup_timer_pkg::RESP_OKAY;
	logic MCLK = 1'b0, SYS_RST = 1'b1, LFO_CLK = 1'b0, THIRD_TIMER_EXPIRED = 1'b0, CARD_PRESENT = 1'b0;
	// Held steady: no reception runs while its count bytes are read
	logic [15:0] THIRD_TIMER_COUNT = 16'ha53c;
	logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'h1;
	logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
	logic S_AXI_RREADY = 1'b0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic WAKEUP_UNDERFLOW_FLAG, WAKEUP_REQUEST, OSC_TRIM_START, CARD_DETECT_START, RF_FIELD_ENABLE;
	logic THIRD_TIMER_START, CARD_DETECT_IRQ, POWER_DOWN_REQUEST;
	int error_cnt = 0, comparisons = 0;
	int n_trim = 0, n_det = 0, n_wake = 0, n_third = 0, n_irq = 0, n_pd = 0;

	wakeup_timer i_wakeup_timer (
		.MCLK(MCLK),
		.SYS_RST(SYS_RST),
		.LFO_CLK(LFO_CLK),
		.THIRD_TIMER_COUNT(THIRD_TIMER_COUNT),
		.THIRD_TIMER_EXPIRED(THIRD_TIMER_EXPIRED),
		.CARD_PRESENT(CARD_PRESENT),
		.S_AXI_AWADDR(S_AXI_AWADDR),
		.S_AXI_AWVALID(S_AXI_AWVALID),
		.S_AXI_AWREADY(S_AXI_AWREADY),
		.S_AXI_WDATA(S_AXI_WDATA),
		.S_AXI_WSTRB(S_AXI_WSTRB),
		.S_AXI_WVALID(S_AXI_WVALID),
		.S_AXI_WREADY(S_AXI_WREADY),
		.S_AXI_BRESP(S_AXI_BRESP),
		.S_AXI_BVALID(S_AXI_BVALID),
		.S_AXI_BREADY(S_AXI_BREADY),
		.S_AXI_ARADDR(S_AXI_ARADDR),
		.S_AXI_ARVALID(S_AXI_ARVALID),
		.S_AXI_ARREADY(S_AXI_ARREADY),
		.S_AXI_RDATA(S_AXI_RDATA),
		.S_AXI_RRESP(S_AXI_RRESP),
		.S_AXI_RVALID(S_AXI_RVALID),
		.S_AXI_RREADY(S_AXI_RREADY),
		.WAKEUP_UNDERFLOW_FLAG(WAKEUP_UNDERFLOW_FLAG),
		.WAKEUP_REQUEST(WAKEUP_REQUEST),
		.OSC_TRIM_START(OSC_TRIM_START),
		.CARD_DETECT_START(CARD_DETECT_START),
		.RF_FIELD_ENABLE(RF_FIELD_ENABLE),
		.THIRD_TIMER_START(THIRD_TIMER_START),
		.CARD_DETECT_IRQ(CARD_DETECT_IRQ),
		.POWER_DOWN_REQUEST(POWER_DOWN_REQUEST)
	);

	always #5 MCLK = ~MCLK;

	// Pulses last one cycle, so tally them rather than poll
	always @(posedge MCLK) begin
		n_trim <= n_trim + OSC_TRIM_START;
		n_det <= n_det + CARD_DETECT_START;
		n_wake <= n_wake + WAKEUP_REQUEST;
		n_third <= n_third + THIRD_TIMER_START;
		n_irq <= n_irq + CARD_DETECT_IRQ;
		n_pd <= n_pd + POWER_DOWN_REQUEST;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		@(posedge MCLK);
		S_AXI_AWADDR <= {22'h0, idx, 2'b00};
		S_AXI_WDATA <= {24'h0, d};
		S_AXI_AWVALID <= 1'b1;
		S_AXI_WVALID <= 1'b1;
		S_AXI_BREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (S_AXI_AWREADY)
				S_AXI_AWVALID <= 1'b0;
			if (S_AXI_WREADY)
				S_AXI_WVALID <= 1'b0;
		end while (S_AXI_BVALID !== 1'b1);
		S_AXI_BREADY <= 1'b0;
		chk("bresp", S_AXI_BRESP, er);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		@(posedge MCLK);
		S_AXI_ARADDR <= {22'h0, idx, 2'b00};
		S_AXI_ARVALID <= 1'b1;
		S_AXI_RREADY <= 1'b1;
		do begin
			@(posedge MCLK);
			if (S_AXI_ARREADY)
				S_AXI_ARVALID <= 1'b0;
		end while (S_AXI_RVALID !== 1'b1);
		S_AXI_RREADY <= 1'b0;
		chk("rdata", S_AXI_RDATA, {24'h0, d});
		chk("rresp", S_AXI_RRESP, er);
	endtask

	// Slow enough for the two-stage synchroniser to see every edge
	task automatic osc(input int n);
		repeat (n) begin
			@(posedge MCLK) LFO_CLK <= 1'b1;
			repeat (4) @(posedge MCLK);
			LFO_CLK <= 1'b0;
			repeat (6) @(posedge MCLK);
		end
	endtask

	task automatic t_reset();
		rd(8'h23, 8'h00, OK);
		rd(8'h24, 8'h00, OK);
		rd(8'h26, 8'h00, OK);
		rd(8'h21, 8'ha5, OK);
		rd(8'h22, 8'h3c, OK);
		rd(8'h30, 8'h00, wakeup_timer_pkg::RESP_SLVERR);
		wr(8'h30, 8'hff, wakeup_timer_pkg::RESP_SLVERR);
	endtask

	task automatic t_oneshot();
		wr(8'h25, 8'h03, OK);
		wr(8'h23, 8'hc0, OK);
		wr(8'h25, 8'h05, OK);
		rd(8'h27, 8'h03, OK);
		osc(2);
		rd(8'h27, 8'h01, OK);
		rd(8'h23, 8'h80, OK);
		osc(1);
		chk("flag", WAKEUP_UNDERFLOW_FLAG, 1'b1);
		rd(8'h27, 8'h00, OK);
		rd(8'h23, 8'h00, OK);
		rd(8'h28, 8'h01, OK);
		wr(8'h28, 8'h01, OK);
		chk("flag", WAKEUP_UNDERFLOW_FLAG, 1'b0);
	endtask

	task automatic t_permit();
		wr(8'h23, 8'h80, OK);
		rd(8'h23, 8'h00, OK);
		wr(8'h23, 8'hc0, OK);
		rd(8'h23, 8'h80, OK);
		rd(8'h27, 8'h05, OK);
		wr(8'h23, 8'h40, OK);
		rd(8'h23, 8'h00, OK);
	endtask

	// Auto-reload of one gives one underflow per tick, whatever the prescaler phase
	task automatic t_divide();
		int k;
		wr(8'h25, 8'h01, OK);
		for (int s = 1; s < 4; s++) begin
			wr(8'h23, 8'hc8 | s[7:0], OK);
			k = 0;
			while (WAKEUP_UNDERFLOW_FLAG !== 1'b1 && k < 40) begin
				osc(1);
				k++;
			end
			wr(8'h28, 8'h01, OK);
			osc((4 << s) - 1);
			chk("early", WAKEUP_UNDERFLOW_FLAG, 1'b0);
			osc(1);
			chk("tick", WAKEUP_UNDERFLOW_FLAG, 1'b1);
			wr(8'h23, 8'h40, OK);
			wr(8'h28, 8'h01, OK);
		end
	endtask

	task automatic t_detect();
		wr(8'h25, 8'h02, OK);
		// Trimming timer taken as set up outside this block, not the third one
		wr(8'h23, 8'hfc, OK);
		osc(2);
		chk("trim", n_trim, 1);
		chk("detect", n_det, 1);
		chk("wake", n_wake, 1);
		chk("field", RF_FIELD_ENABLE, 1'b1);
		rd(8'h27, 8'h02, OK);
		CARD_PRESENT <= 1'b1;
		repeat (6) @(posedge MCLK);
		THIRD_TIMER_EXPIRED <= 1'b1;
		repeat (8) @(posedge MCLK);
		chk("irq", n_irq, 1);
		chk("field", RF_FIELD_ENABLE, 1'b0);
		rd(8'h28, 8'h05, OK);
		CARD_PRESENT <= 1'b0;
		THIRD_TIMER_EXPIRED <= 1'b0;
		osc(2);
		THIRD_TIMER_EXPIRED <= 1'b1;
		repeat (8) @(posedge MCLK);
		chk("sleep", n_pd, 1);
		chk("third", n_third, 2);
		// Auto-wake cleared: a card-less sequence must leave the device active
		THIRD_TIMER_EXPIRED <= 1'b0;
		wr(8'h23, 8'hd0, OK);
		osc(2);
		THIRD_TIMER_EXPIRED <= 1'b1;
		repeat (8) @(posedge MCLK);
		chk("stay", n_pd, 1);
		chk("nowake", n_wake, 2);
		chk("third", n_third, 3);
		wr(8'h23, 8'h40, OK);
	endtask

	task automatic print_verdict();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge MCLK);
		error_cnt++;
		print_verdict();
	end

	initial begin
		repeat (16) @(posedge MCLK);
		SYS_RST <= 1'b0;
		t_reset();
		t_oneshot();
		t_permit();
		t_divide();
		t_detect();
		print_verdict();
	end
endmodule

// ### verif/wakeup_timer_monitor.sv
module wakeup_timer_monitor (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic WAKEUP_REQUEST,
	input wire logic OSC_TRIM_START,
	input wire logic CARD_DETECT_START,
	input wire logic RF_FIELD_ENABLE,
	input wire logic THIRD_TIMER_START,
	input wire logic CARD_DETECT_IRQ,
	input wire logic POWER_DOWN_REQUEST
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	// Reset itself is the cause here, so it cannot also disable
	chk_rst_quiet: assert property (disable iff (1'b0)
		SYS_RST |=> !S_AXI_BVALID && !S_AXI_RVALID && !RF_FIELD_ENABLE) else $error("busy after reset");
	chk_rd_latency: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read answer late");
	chk_rd_hold: assert property (
		S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
	chk_wr_answer: assert property (
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
		else $error("write answer late");
	chk_b_hold: assert property (
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
	chk_ar_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read taken while busy");
	chk_trim_pulse: assert property (OSC_TRIM_START |=> !OSC_TRIM_START) else $error("trim start too long");
	chk_detect_field: assert property (
		CARD_DETECT_START |-> ##[0:2] RF_FIELD_ENABLE) else $error("no field for detection");
	chk_field_on: assert property (
		THIRD_TIMER_START |-> ##[0:1] RF_FIELD_ENABLE) else $error("field off at third start");
	chk_end_single: assert property (
		!(CARD_DETECT_IRQ && POWER_DOWN_REQUEST)) else $error("irq and sleep together");
	chk_wake_pulse: assert property (WAKEUP_REQUEST |=> !WAKEUP_REQUEST) else $error("wake too long");
endmodule

bind wakeup_timer wakeup_timer_monitor i_wakeup_timer_monitor (
	.MCLK(MCLK),
	.SYS_RST(SYS_RST),
	.S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BRESP(S_AXI_BRESP),
	.S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY),
	.WAKEUP_REQUEST(WAKEUP_REQUEST),
	.OSC_TRIM_START(OSC_TRIM_START),
	.CARD_DETECT_START(CARD_DETECT_START),
	.RF_FIELD_ENABLE(RF_FIELD_ENABLE),
	.THIRD_TIMER_START(THIRD_TIMER_START),
	.CARD_DETECT_IRQ(CARD_DETECT_IRQ),
	.POWER_DOWN_REQUEST(POWER_DOWN_REQUEST)
);

// ### verilog/wakeup_timer.sv
// Our own choice: register access over AXI4-Lite.
module wakeup_timer (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic LFO_CLK,
	input wire logic [15:0] THIRD_TIMER_COUNT,
	input wire logic THIRD_TIMER_EXPIRED,
	input wire logic CARD_PRESENT,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic WAKEUP_UNDERFLOW_FLAG,
	output logic WAKEUP_REQUEST,
	output logic OSC_TRIM_START,
	output logic CARD_DETECT_START,
	output logic RF_FIELD_ENABLE,
	output logic THIRD_TIMER_START,
	output logic CARD_DETECT_IRQ,
	output logic POWER_DOWN_REQUEST
);

	// Register word index from a byte address; misaligned or high bits unmapped
	function automatic logic [8:0] word_index(input logic [31:0] addr);
		if (addr[1:0] != 2'b00 || addr[31:10] != 22'h0)
			word_index = 9'h1ff;
		else
			word_index = {1'b0, addr[9:2]};
	endfunction

	wakeup_timer_pkg::control_s control;
	logic running;
	logic [15:0] reload_value;
	logic [15:0] count;
	logic flag;
	wakeup_timer_pkg::detect_e det_state;
	logic card_seen;

	// Synchronisers for the oscillator and external inputs, and oscillator edge detection
	logic lfo_meta;
	logic lfo_sync;
	logic lfo_prev;
	logic [15:0] third_meta;
	logic [15:0] third_sync;
	logic exp_meta;
	logic exp_sync;
	logic card_meta;
	logic card_sync;

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			lfo_meta <= 1'b0;
			lfo_sync <= 1'b0;
			lfo_prev <= 1'b0;
			third_meta <= 16'h0000;
			third_sync <= 16'h0000;
			exp_meta <= 1'b0;
			exp_sync <= 1'b0;
			card_meta <= 1'b0;
			card_sync <= 1'b0;
		end else begin
			lfo_meta <= LFO_CLK;
			lfo_sync <= lfo_meta;
			lfo_prev <= lfo_sync;
			// Count may tear while changing; software must not read it mid-reception
			third_meta <= THIRD_TIMER_COUNT;
			third_sync <= third_meta;
			exp_meta <= THIRD_TIMER_EXPIRED;
			exp_sync <= exp_meta;
			card_meta <= CARD_PRESENT;
			card_sync <= card_meta;
		end
	end

	logic lfo_rise;
	assign lfo_rise = lfo_sync & ~lfo_prev;

	// Prescaler: one-cycle tick every N oscillator rising edges
	logic [5:0] div_count;
	logic [5:0] div_limit;
	logic tick;

	always_comb begin
		case (control.clk_sel)
			2'b00: div_limit = wakeup_timer_pkg::DIV_1;
			2'b01: div_limit = wakeup_timer_pkg::DIV_8;
			2'b10: div_limit = wakeup_timer_pkg::DIV_16;
			default: div_limit = wakeup_timer_pkg::DIV_32;
		endcase
	end

	assign tick = running && lfo_rise && (div_count + 6'h01 >= div_limit);

	always_ff @(posedge MCLK) begin
		if (SYS_RST || !running)
			div_count <= 6'h00;
		else if (lfo_rise)
			div_count <= tick ? 6'h00 : div_count + 6'h01;
	end

	// AXI write channel
	logic aw_held;
	logic w_held;
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic [8:0] w_index;

	assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
	assign do_write = aw_held && w_held;
	assign w_index = word_index(aw_addr);

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			aw_held <= 1'b0;
			aw_addr <= 32'h0;
		end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			aw_held <= 1'b1;
			aw_addr <= S_AXI_AWADDR;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else if (S_AXI_WVALID && S_AXI_WREADY) begin
			w_held <= 1'b1;
			w_data <= S_AXI_WDATA;
			w_strb <= S_AXI_WSTRB;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	logic hit_control;
	logic hit_reload_high;
	logic hit_reload_low;
	logic w_mapped;

	assign w_mapped = (w_index >= {1'b0, wakeup_timer_pkg::IDX_THIRD_COUNT_HIGH})
		&& (w_index <= {1'b0, wakeup_timer_pkg::IDX_STATUS});
	assign hit_control = do_write && w_strb[0] && w_index == {1'b0, wakeup_timer_pkg::IDX_CONTROL};
	assign hit_reload_high = do_write && w_strb[0] && w_index == {1'b0, wakeup_timer_pkg::IDX_RELOAD_HIGH};
	assign hit_reload_low = do_write && w_strb[0] && w_index == {1'b0, wakeup_timer_pkg::IDX_RELOAD_LOW};

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= wakeup_timer_pkg::RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= w_mapped ? wakeup_timer_pkg::RESP_OKAY : wakeup_timer_pkg::RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// Control and reload registers
	always_ff @(posedge MCLK) begin
		if (SYS_RST)
			control <= wakeup_timer_pkg::CONTROL_RESET;
		else if (hit_control)
			control <= w_data[wakeup_timer_pkg::CTL_TRIM:0];
	end

	// A reload byte written mid-count is only picked up at the next start or auto reload
	always_ff @(posedge MCLK) begin
		if (SYS_RST)
			reload_value <= wakeup_timer_pkg::RELOAD_RESET;
		else if (hit_reload_high)
			reload_value[15:8] <= w_data[7:0];
		else if (hit_reload_low)
			reload_value[7:0] <= w_data[7:0];
	end

	// Start event: running written 1 through the permit bit, even while already running
	logic run_write;
	logic start_event;
	logic underflow;
	logic auto_reload;

	assign run_write = hit_control && w_data[wakeup_timer_pkg::CTL_PERMIT];
	assign start_event = run_write && w_data[wakeup_timer_pkg::CTL_RUNNING];
	assign underflow = tick && count == 16'h0001;
	// Card detection keeps the timer cycling even without auto reload
	assign auto_reload = control.reload || control.detect;

	always_ff @(posedge MCLK) begin
		if (SYS_RST)
			running <= 1'b0;
		else if (run_write)
			running <= w_data[wakeup_timer_pkg::CTL_RUNNING];
		else if (underflow && !auto_reload)
			running <= 1'b0;
		else if (running && count == 16'h0000 && !auto_reload)
			running <= 1'b0;
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST)
			count <= 16'h0000;
		else if (start_event)
			count <= reload_value;
		else if (underflow && auto_reload)
			count <= reload_value;
		else if (tick && count != 16'h0000)
			count <= count - 16'h0001;
	end

	// Underflow flag: set wins over the clear from software
	logic flag_clear;
	logic [8:0] s_index;
	logic hit_status;

	assign hit_status = do_write && w_strb[0] && w_index == {1'b0, wakeup_timer_pkg::IDX_STATUS};
	assign flag_clear = hit_status && w_data[wakeup_timer_pkg::STS_FLAG];

	always_ff @(posedge MCLK) begin
		if (SYS_RST)
			flag <= 1'b0;
		else if (underflow)
			flag <= 1'b1;
		else if (flag_clear)
			flag <= 1'b0;
	end

	// Underflow-driven event pulses
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			WAKEUP_REQUEST <= 1'b0;
			OSC_TRIM_START <= 1'b0;
			CARD_DETECT_START <= 1'b0;
		end else begin
			WAKEUP_REQUEST <= underflow && control.resume;
			OSC_TRIM_START <= underflow && control.trim;
			CARD_DETECT_START <= underflow && control.detect;
		end
	end

	// Card detection sequence: field held on until third timer expires
	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			det_state <= wakeup_timer_pkg::DET_IDLE;
			RF_FIELD_ENABLE <= 1'b0;
			THIRD_TIMER_START <= 1'b0;
			CARD_DETECT_IRQ <= 1'b0;
			POWER_DOWN_REQUEST <= 1'b0;
			card_seen <= 1'b0;
		end else begin
			THIRD_TIMER_START <= 1'b0;
			CARD_DETECT_IRQ <= 1'b0;
			POWER_DOWN_REQUEST <= 1'b0;
			case (det_state)
				wakeup_timer_pkg::DET_IDLE: begin
					if (underflow && control.detect) begin
						det_state <= wakeup_timer_pkg::DET_FIELD;
						RF_FIELD_ENABLE <= 1'b1;
						THIRD_TIMER_START <= 1'b1;
						card_seen <= 1'b0;
					end
				end
				wakeup_timer_pkg::DET_FIELD: begin
					if (card_sync)
						card_seen <= 1'b1;
					if (exp_sync && !THIRD_TIMER_START) begin
						RF_FIELD_ENABLE <= 1'b0;
						det_state <= wakeup_timer_pkg::DET_DONE;
					end
				end
				default: begin
					det_state <= wakeup_timer_pkg::DET_IDLE;
					if (card_seen)
						CARD_DETECT_IRQ <= 1'b1;
					else
						POWER_DOWN_REQUEST <= control.resume;
				end
			endcase
		end
	end

	assign WAKEUP_UNDERFLOW_FLAG = flag;

	// Status word assembled from the package bit positions
	logic [7:0] status_word;

	always_comb begin
		status_word = 8'h00;
		status_word[wakeup_timer_pkg::STS_FLAG] = flag;
		status_word[wakeup_timer_pkg::STS_DETECT_BUSY] = det_state != wakeup_timer_pkg::DET_IDLE;
		status_word[wakeup_timer_pkg::STS_CARD_SEEN] = card_seen;
	end

	// AXI read channel
	logic [7:0] read_byte;
	logic r_mapped;

	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign s_index = word_index(S_AXI_ARADDR);

	always_comb begin
		read_byte = 8'h00;
		r_mapped = 1'b1;
		if (s_index == {1'b0, wakeup_timer_pkg::IDX_THIRD_COUNT_HIGH})
			read_byte = third_sync[15:8];
		else if (s_index == {1'b0, wakeup_timer_pkg::IDX_THIRD_COUNT_LOW})
			read_byte = third_sync[7:0];
		// Permit bit is write-only, so it always reads back as zero
		else if (s_index == {1'b0, wakeup_timer_pkg::IDX_CONTROL})
			read_byte = {running, 1'b0, control};
		else if (s_index == {1'b0, wakeup_timer_pkg::IDX_RELOAD_HIGH})
			read_byte = reload_value[15:8];
		else if (s_index == {1'b0, wakeup_timer_pkg::IDX_RELOAD_LOW})
			read_byte = reload_value[7:0];
		else if (s_index == {1'b0, wakeup_timer_pkg::IDX_COUNT_HIGH})
			read_byte = count[15:8];
		else if (s_index == {1'b0, wakeup_timer_pkg::IDX_COUNT_LOW})
			read_byte = count[7:0];
		else if (s_index == {1'b0, wakeup_timer_pkg::IDX_STATUS})
			read_byte = status_word;
		else
			r_mapped = 1'b0;
	end

	always_ff @(posedge MCLK) begin
		if (SYS_RST) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= wakeup_timer_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= {24'h0, read_byte};
			S_AXI_RRESP <= r_mapped ? wakeup_timer_pkg::RESP_OKAY : wakeup_timer_pkg::RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

endmodule

// ### verilog/wakeup_timer_pkg.sv
package wakeup_timer_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_THIRD_COUNT_HIGH = 8'h21;
	localparam logic [7:0] IDX_THIRD_COUNT_LOW = 8'h22;
	localparam logic [7:0] IDX_CONTROL = 8'h23;
	localparam logic [7:0] IDX_RELOAD_HIGH = 8'h24;
	localparam logic [7:0] IDX_RELOAD_LOW = 8'h25;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'h26;
	localparam logic [7:0] IDX_COUNT_LOW = 8'h27;
	localparam logic [7:0] IDX_STATUS = 8'h28;

	// Control bit positions
	localparam int CTL_RUNNING = 7;
	localparam int CTL_PERMIT = 6;
	localparam int CTL_TRIM = 5;
	localparam int CTL_DETECT = 4;
	localparam int CTL_RELOAD = 3;
	localparam int CTL_RESUME = 2;
	localparam int CTL_CLK_HI = 1;

	// Status bit positions
	localparam int STS_FLAG = 0;
	localparam int STS_DETECT_BUSY = 1;
	localparam int STS_CARD_SEEN = 2;

	// Reset values
	localparam logic [5:0] CONTROL_RESET = 6'h00;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;

	// Oscillator tick prescale per clock select
	localparam logic [5:0] DIV_1 = 6'h01;
	localparam logic [5:0] DIV_8 = 6'h08;
	localparam logic [5:0] DIV_16 = 6'h10;
	localparam logic [5:0] DIV_32 = 6'h20;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic trim;
		logic detect;
		logic reload;
		logic resume;
		logic [1:0] clk_sel;
	} control_s;

	typedef enum logic [1:0] {
		DET_IDLE,
		DET_FIELD,
		DET_DONE
	} detect_e;

endpackage
